// *** hdl/sbg_majority.sv ***
/*
  Three-sample majority voter for the receive line.
  Assumes a synchronised pin level and a one-cycle sample strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module sbg_majority (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample strobe, pin level and result
  sbg_vote_if.voter vote
);

  // Last three samples, newest in bit 0
  logic [2:0] samples;
  // Voted level register
  logic level_q;

  // Majority of three samples
  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samples <= sbg_pkg::SAMPLE_RESET;
    end else if (vote.sample_en) begin
      samples <= {samples[1:0], vote.pin_level};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b1;
    end else begin
      level_q <= majority3(samples);
    end
  end

  assign vote.level = level_q;

endmodule

`default_nettype wire

// *** hdl/sbg_pkg.sv ***
/*
  Constants, types and helpers shared by the baud tick generator files:
  register indices and byte addresses, field positions, reset values,
  postscaler terminals and the decoded operating mode.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package sbg_pkg;

  // Bus address width in bits
  localparam int ADDR_W = 12;

  // Register indices as printed; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_RCV = 12'h018;
  localparam logic [ADDR_W-1:0] IDX_XMT = 12'h098;
  localparam logic [ADDR_W-1:0] IDX_DIV = 12'h099;
  localparam logic [ADDR_W-1:0] IDX_STAT = 12'h09a;

  // Byte lane shift between index and byte address
  localparam int IDX_SHIFT = 2;

  // Transmit status/control field positions
  localparam int XMT_CLOCK_SOURCE_SELECT = 7;
  localparam int XMT_SYNC = 4;
  localparam int XMT_HIGH_SPEED_SELECT = 2;
  // Receive status/control: serial port enable
  localparam int RCV_SPEN = 7;

  // Writable bit masks; other bits read back fixed
  localparam logic [7:0] RCV_WMASK = 8'hf8;
  localparam logic [7:0] XMT_WMASK = 8'hf5;

  // Reset values
  localparam logic [7:0] RCV_RESET = 8'h00;
  localparam logic [7:0] XMT_RESET = 8'h02;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [2:0] SAMPLE_RESET = 3'h7;

  // Status word field positions
  localparam int STAT_RX_BIT = 8;
  localparam int STAT_MASTER_BIT = 9;
  localparam int STAT_PS_LSB = 16;

  // Postscaler terminal counts: ticks per bit minus one
  localparam int PS_W = 6;
  localparam logic [PS_W-1:0] PS_LOW = 6'h3f;
  localparam logic [PS_W-1:0] PS_HIGH = 6'h0f;
  localparam logic [PS_W-1:0] PS_SYNC = 6'h03;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operating mode decoded from the control bits
  typedef enum logic [1:0] {
    SBG_ASYNC_LOW,
    SBG_ASYNC_HIGH,
    SBG_SYNC_MASTER,
    SBG_SYNC_SLAVE
  } sbg_mode_t;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] idx);
    reg_addr = idx << IDX_SHIFT;
  endfunction

  // Mode from transmit control; speed bit is ignored when synchronous
  function automatic sbg_mode_t decode_mode(input logic [7:0] xmt);
    if (xmt[XMT_SYNC]) begin
      decode_mode = xmt[XMT_CLOCK_SOURCE_SELECT] ? SBG_SYNC_MASTER : SBG_SYNC_SLAVE;
    end else begin
      decode_mode = xmt[XMT_HIGH_SPEED_SELECT] ? SBG_ASYNC_HIGH : SBG_ASYNC_LOW;
    end
  endfunction

  // Postscaler terminal for a mode
  function automatic logic [PS_W-1:0] ps_terminal(input sbg_mode_t m);
    unique case (m)
      SBG_ASYNC_LOW: ps_terminal = PS_LOW;
      SBG_ASYNC_HIGH: ps_terminal = PS_HIGH;
      SBG_SYNC_MASTER, SBG_SYNC_SLAVE: ps_terminal = PS_SYNC;
    endcase
  endfunction

endpackage

// *** hdl/sbg_top.sv ***
/*
  Baud tick generator with receive-line majority sampler, behind an
  AXI4-Lite register slave. Holds the divisor, the two status/control
  registers and a status word showing timer and sampler state.
  Assumes one clock, a synchronous active-low reset, and pins that are
  asynchronous to the clock (they pass two flip-flops first).
*/
`timescale 1ns/1ps
`default_nettype none

module sbg_top #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [sbg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [sbg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins from the peer
  input wire logic receive_data_pin,
  input wire logic ext_clock_pin,
  // Tick and level outputs to the transceiver
  output logic baud_tick,
  output logic sample_tick,
  output logic bit_tick,
  output logic rx_level,
  output logic master_mode,
  output logic serial_enable
);

  // Registers seen by software
  logic [7:0] receive_status_control;
  logic [7:0] transmit_status_control;
  logic [DIV_W-1:0] rate_divisor_value;

  // Write channel holding state
  logic aw_held;
  logic w_held;
  logic [sbg_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // One-cycle write commit strobe
  logic wr_commit;
  // Commit targets the divisor with its low lane enabled
  logic div_wr;
  // Address decode for the commit
  logic wr_mapped;

  // Read path
  logic [31:0] read_value;
  logic rd_mapped;

  // Timer and postscaler
  logic [DIV_W-1:0] baud_tick_generator;
  logic [sbg_pkg::PS_W-1:0] ps_count;
  logic timer_hit;
  logic ps_hit;
  sbg_pkg::sbg_mode_t mode;

  // Pin synchronisers and clock edge detect
  logic rx_meta;
  logic rx_sync;
  logic ck_meta;
  logic ck_sync;
  logic ck_prev;
  logic ck_rise;

  // Link to the majority voter
  sbg_vote_if vote ();

  // True when an address hits a mapped register
  function automatic logic addr_mapped(input logic [sbg_pkg::ADDR_W-1:0] a);
    addr_mapped = (a == sbg_pkg::reg_addr(sbg_pkg::IDX_RCV)) ||
                  (a == sbg_pkg::reg_addr(sbg_pkg::IDX_XMT)) ||
                  (a == sbg_pkg::reg_addr(sbg_pkg::IDX_DIV)) ||
                  (a == sbg_pkg::reg_addr(sbg_pkg::IDX_STAT));
  endfunction

  // mode bit picks sync or async
  // clock source picks master or slave
  assign mode = sbg_pkg::decode_mode(transmit_status_control);

  // Write commits once both address and data are held
  assign wr_commit = aw_held && w_held && !s_axi_bvalid;
  assign wr_mapped = addr_mapped(aw_addr);
  assign div_wr = wr_commit && w_strb[0] &&
                  (aw_addr == sbg_pkg::reg_addr(sbg_pkg::IDX_DIV));

  // timer reaches terminal count at zero
  // A restart write takes precedence over a pending terminal count
  assign timer_hit = (baud_tick_generator == '0) && !div_wr;
  assign ps_hit = timer_hit && (ps_count >= sbg_pkg::ps_terminal(mode));

  // Only the second and third flops are read by logic
  assign ck_rise = ck_sync && !ck_prev;

  // Receive pin synchroniser; the line idles high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= receive_data_pin;
      rx_sync <= rx_meta;
    end
  end

  // External shift clock synchroniser and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_prev <= 1'b0;
    end else begin
      ck_meta <= ext_clock_pin;
      ck_sync <= ck_meta;
      ck_prev <= ck_sync;
    end
  end

  // Write address channel: accept once, hold until the response leaves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_commit) begin
      aw_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // Ready again only after the response is taken
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel: same pattern as the address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_commit) begin
      w_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response: unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sbg_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_status_control <= sbg_pkg::RCV_RESET;
      transmit_status_control <= sbg_pkg::XMT_RESET;
    end else if (wr_commit && w_strb[0]) begin
      if (aw_addr == sbg_pkg::reg_addr(sbg_pkg::IDX_RCV)) begin
        // Status bits stay clear: no receiver here to set them
        receive_status_control <= w_data[7:0] & sbg_pkg::RCV_WMASK;
      end else if (aw_addr == sbg_pkg::reg_addr(sbg_pkg::IDX_XMT)) begin
        // Shift register reads empty, unused bit reads zero
        transmit_status_control <= (w_data[7:0] & sbg_pkg::XMT_WMASK) |
                                   (sbg_pkg::XMT_RESET & ~sbg_pkg::XMT_WMASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_divisor_value <= sbg_pkg::DIV_RESET;
    end else if (div_wr) begin
      rate_divisor_value <= w_data[DIV_W-1:0];
    end
  end

  // Read data selection; status word exposes live generator state
  always_comb begin
    read_value = '0;
    rd_mapped = addr_mapped(s_axi_araddr);
    if (s_axi_araddr == sbg_pkg::reg_addr(sbg_pkg::IDX_RCV)) begin
      read_value[7:0] = receive_status_control;
    end else if (s_axi_araddr == sbg_pkg::reg_addr(sbg_pkg::IDX_XMT)) begin
      read_value[7:0] = transmit_status_control;
    end else if (s_axi_araddr == sbg_pkg::reg_addr(sbg_pkg::IDX_DIV)) begin
      read_value[DIV_W-1:0] = rate_divisor_value;
    end else if (s_axi_araddr == sbg_pkg::reg_addr(sbg_pkg::IDX_STAT)) begin
      read_value[DIV_W-1:0] = baud_tick_generator;
      read_value[sbg_pkg::STAT_RX_BIT] = rx_level;
      read_value[sbg_pkg::STAT_MASTER_BIT] = master_mode;
      read_value[sbg_pkg::STAT_PS_LSB +: sbg_pkg::PS_W] = ps_count;
    end
  end

  // Read address and data: one read at a time, answer next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sbg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= rd_mapped ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // single 8-bit down-timer for every mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_tick_generator <= '0;
    end else if (div_wr) begin
      baud_tick_generator <= w_data[DIV_W-1:0];
    end else if (timer_hit) begin
      baud_tick_generator <= rate_divisor_value;
    end else begin
      baud_tick_generator <= baud_tick_generator - 1'b1;
    end
  end

  // Postscaler dividing timer ticks into bit periods
  // Uses >= so a mode change mid-count cannot run past the terminal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_count <= '0;
    end else if (div_wr) begin
      // the bit period restarts with the timer
      ps_count <= '0;
    end else if (ps_hit) begin
      ps_count <= '0;
    end else if (timer_hit) begin
      ps_count <= ps_count + 1'b1;
    end
  end

  // one-cycle tick at every terminal count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= timer_hit;
    end
  end

  // async sample clock is the raw timer tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= timer_hit &&
                     (mode == sbg_pkg::SBG_ASYNC_LOW || mode == sbg_pkg::SBG_ASYNC_HIGH);
    end
  end

  // Bit rate tick per mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_tick <= 1'b0;
    end else begin
      unique case (mode)
        sbg_pkg::SBG_ASYNC_LOW, sbg_pkg::SBG_ASYNC_HIGH, sbg_pkg::SBG_SYNC_MASTER: begin
          bit_tick <= ps_hit;
        end
        // slave follows the peer's clock edges
        sbg_pkg::SBG_SYNC_SLAVE: begin
          bit_tick <= ck_rise;
        end
      endcase
    end
  end

  // Mode and enable flags for the transceiver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_mode <= 1'b0;
      serial_enable <= 1'b0;
    end else begin
      // master only when synchronous with clock source set
      master_mode <= (mode == sbg_pkg::SBG_SYNC_MASTER);
      serial_enable <= receive_status_control[sbg_pkg::RCV_SPEN];
    end
  end

  // sample on timer ticks, or on peer clock edges as slave
  assign vote.sample_en = timer_hit || (mode == sbg_pkg::SBG_SYNC_SLAVE && ck_rise);
  assign vote.pin_level = rx_sync;

  // Majority voter for the receive line
  sbg_majority u_vote (
    .aclk(aclk),
    .aresetn(aresetn),
    .vote(vote.voter)
  );

  // Voted level comes straight from the voter's register
  assign rx_level = vote.level;

endmodule

`default_nettype wire

// *** hdl/sbg_vote_if.sv ***
/*
  Interface between the generator top and the majority voter.
  Assumes both ends share the top's clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface sbg_vote_if;
  // One-cycle strobe: take a sample now
  logic sample_en;
  // Synchronised receive pin level
  logic pin_level;
  // Voted receive level
  logic level;

  modport gen (output sample_en, output pin_level, input level);
  modport voter (input sample_en, input pin_level, output level);
endinterface

`default_nettype wire

// *** tb/sbg_monitor.sv ***
/* Checker for the generator top: tick spacing, restart, reset, bus holds.
   Assumes it sees only top ports and that writes offer AW and W together. */
`timescale 1ns/1ps
`default_nettype none
module sbg_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [sbg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Generator outputs
  input wire logic baud_tick,
  input wire logic sample_tick,
  input wire logic bit_tick,
  input wire logic rx_level,
  input wire logic master_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam logic [11:0] A_XMT = sbg_pkg::IDX_XMT << 2;
  localparam logic [11:0] A_DIV = sbg_pkg::IDX_DIV << 2;
  // Shadows of divisor and mode; gap and settling counters
  logic [7:0] div, xmt;
  logic [15:0] gap, bgap, sw, k;
  logic [1:0] n, bn;
  logic wt, wr;
  // Write taken with the low byte enabled
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  // Bit spacing less one; speed bit ignored once synchronous
  assign k = (16'(div) + 16'h1) * (xmt[4] ? 16'h4 : xmt[2] ? 16'h10 : 16'h40) - 16'h1;
  // Shadows follow the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 8'h0;
      xmt <= 8'h2;
    end else if (wr && s_axi_awaddr == A_DIV) begin
      div <= s_axi_wdata[7:0];
    end else if (wr && s_axi_awaddr == A_XMT) begin
      xmt <= s_axi_wdata[7:0];
    end
  end
  // Any write may leave a stale period, so wait a few ticks before judging
  always_ff @(posedge aclk) begin
    if (!aresetn || wr) begin
      n <= 2'h0;
      bn <= 2'h0;
    end else begin
      if (baud_tick && n != 2'h2) n <= n + 2'h1;
      if (bit_tick && bn != 2'h3) bn <= bn + 2'h1;
    end
  end
  // Idle cycles since the last baud tick and the last bit tick
  always_ff @(posedge aclk) begin
    gap <= (!aresetn || baud_tick) ? 16'h0 : gap + 16'h1;
    bgap <= (!aresetn || bit_tick) ? 16'h0 : bgap + 16'h1;
  end
  // Cycles since a divisor write; wt marks its first tick as pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wt <= 1'h0;
      sw <= 16'h0;
    end else if (wr && s_axi_awaddr == A_DIV) begin
      wt <= 1'h1;
      sw <= 16'h0;
    end else begin
      sw <= sw + 16'h1;
      if (baud_tick && sw != 16'h0) wt <= 1'h0;
    end
  end
  reset_idle_a: assert property ($rose(aresetn) |-> rx_level && !baud_tick && !bit_tick && !master_mode)
    else $error("outputs not idle after reset");
  tick_period_a: assert property (baud_tick && n == 2'h2 |-> gap == 16'(div))
    else $error("baud tick spacing wrong");
  bit_period_a: assert property (bit_tick && bn == 2'h3 && !(xmt[4] && !xmt[7]) |-> bgap == k)
    else $error("bit tick spacing wrong");
  timer_restart_a: assert property (baud_tick && wt && sw != 16'h0 |-> sw == 16'(div) + 16'h2)
    else $error("first tick after divisor write late or early");
  sample_pair_a: assert property (sample_tick |-> baud_tick)
    else $error("sample tick without baud tick");
  master_tick_a: assert property (bit_tick && master_mode |-> baud_tick)
    else $error("master bit tick not from generator");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  write_turn_a: assert property (wr |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response timing wrong");
endmodule
`default_nettype wire

// *** tb/sbg_peer.sv ***
/* Peer serial device: drives the receive line and the shift clock.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module sbg_peer (
  // Pacing clock
  input wire logic aclk,
  // Lines into the generator
  output logic receive_data_pin,
  output logic ext_clock_pin
);
  // Line idles high, clock rests low between frames
  initial begin
    receive_data_pin = 1'h1;
    ext_clock_pin = 1'h0;
  end
  task automatic drive_low(input int n);
    receive_data_pin <= 1'h0;
    repeat (n) @(posedge aclk);
    receive_data_pin <= 1'h1;
  endtask
  task automatic clock_out(input int n);
    repeat (n) begin
      ext_clock_pin <= 1'h1;
      repeat (4) @(posedge aclk);
      ext_clock_pin <= 1'h0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb/test_serial_baud_rate_generator.sv ***
/* Bench: bus tasks, reference registers, tick timing per mode, vote, slave clock.
   Assumes the package, top, peer and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module test_serial_baud_rate_generator;
  // Byte addresses and one hole
  localparam logic [11:0] A_RCV = sbg_pkg::IDX_RCV << 2;
  localparam logic [11:0] A_XMT = sbg_pkg::IDX_XMT << 2;
  localparam logic [11:0] A_DIV = sbg_pkg::IDX_DIV << 2;
  // Master side signals
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lo;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic receive_data_pin, ext_clock_pin;
  logic baud_tick, sample_tick, bit_tick, rx_level, master_mode, serial_enable;
  // Reference registers and counters
  int n_errors = 0, compares = 0, seed = 98, n_sample = 0, n_bit = 0, c, x, t;
  int m [3] = '{0, 2, 0};
  logic [11:0] addrs [4] = '{A_RCV, A_XMT, A_DIV, 12'h100};
  logic [7:0] modes [4] = '{8'h80, 8'h04, 8'h90, 8'h94};
  int kf [4] = '{64, 16, 4, 4};
  wire logic [2:0] ticks = {bit_tick, sample_tick, baud_tick};
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (sample_tick === 1'h1) n_sample <= n_sample + 1;
    if (bit_tick === 1'h1) n_bit <= n_bit + 1;
  end
  sbg_top i_sbg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .receive_data_pin, .ext_clock_pin, .baud_tick, .sample_tick, .bit_tick, .rx_level,
    .master_mode, .serial_enable);
  sbg_peer i_sbg_peer (.aclk, .receive_data_pin, .ext_clock_pin);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Reference slot of an address, -1 for a hole
  function automatic int slot(input logic [11:0] a);
    slot = (a == A_RCV) ? 0 : (a == A_XMT) ? 1 : (a == A_DIV) ? 2 : -1;
  endfunction
  // Write through the bus; each channel released once taken
  task automatic put(input logic [11:0] a, input int v);
    int s;
    logic ad, wd;
    s = slot(a);
    {ad, wd} = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin ad = 1'h1; s_axi_awvalid <= 1'h0; end
      if (s_axi_wvalid && s_axi_wready) begin wd = 1'h1; s_axi_wvalid <= 1'h0; end
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), s < 0 ? 32'h2 : 32'h0);
    // Lane 0 off: answered but nothing stored
    if (s >= 0 && s_axi_wstrb[0]) m[s] = (s == 0) ? v & 'hf8 : (s == 1) ? (v & 'hf5) | 'h02 : v & 'hff;
  endtask
  // Read and compare with the reference
  task automatic look(input logic [11:0] a);
    int s;
    s = slot(a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    repeat (2) @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, s < 0 ? 32'h0 : 32'(m[s]));
    chk(32'(s_axi_rresp), s < 0 ? 32'h2 : 32'h0);
  endtask
  // Cycles from one pulse of a tick kind to the next
  task automatic gap(input int s, output int g);
    g = 0;
    do @(posedge aclk); while (ticks[s] !== 1'h1);
    do begin @(posedge aclk); g++; end while (ticks[s] !== 1'h1);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(32'(rx_level), 32'h1);
    foreach (addrs[i]) look(addrs[i]);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      put(addrs[i % 4], $random(seed));
      look(addrs[i % 4]);
    end
    s_axi_wstrb <= 4'he;
    put(A_DIV, 'h5a);
    s_axi_wstrb <= 4'hf;
    look(A_DIV);
    put(A_RCV, 'h80);
    chk(32'(serial_enable), 32'h1);
    $display("test registers done");
    foreach (modes[i]) begin
      x = $random(seed) & 3;
      put(A_XMT, modes[i]);
      put(A_DIV, x);
      chk(32'(master_mode), 32'(i >= 2));
      gap(0, c);
      gap(0, c);
      chk(c, x + 1);
      gap(2, c);
      gap(2, c);
      chk(c, (x + 1) * kf[i]);
      t = n_sample;
      repeat (40) @(posedge aclk);
      chk(32'(n_sample != t), 32'(i < 2));
    end
    $display("test modes done");
    put(A_XMT, 'h04);
    put(A_DIV, 255);
    gap(0, c);
    chk(c, 256);
    put(A_DIV, 1);
    for (t = 0; baud_tick !== 1'h1; t++) @(posedge aclk);
    chk(32'(t < 4), 32'h1);
    $display("test restart done");
    put(A_DIV, 0);
    for (int w = 1; w < 3; w++) begin
      i_sbg_peer.drive_low(w);
      lo = 1'h0;
      repeat (12) @(posedge aclk) if (rx_level === 1'h0) lo = 1'h1;
      chk(32'(lo), 32'(w > 1));
    end
    $display("test vote done");
    put(A_XMT, 'h10);
    chk(32'(master_mode), 32'h0);
    t = n_bit;
    i_sbg_peer.clock_out(5);
    repeat (8) @(posedge aclk);
    chk(n_bit - t, 5);
    $display("test slave done");
    // Mid-run reset: registers, timer and sampler start over
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    m = '{0, 2, 0};
    @(posedge aclk);
    chk(32'(rx_level), 32'h1);
    chk(32'(master_mode), 32'h0);
    foreach (addrs[i]) look(addrs[i]);
    $display("test second reset done");
    results();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule
bind sbg_top sbg_monitor i_sbg_monitor (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .baud_tick, .sample_tick, .bit_tick, .rx_level, .master_mode);
`default_nettype wire
